// >>> ttm_pkg.sv
// package: constants and carrier types for the trail trace / tandem monitor
package ttm_pkg;

	// ------------------------------------------------------------------
	// trace message framing
	// ------------------------------------------------------------------
	localparam int TRACE_LEN = 16;
	localparam logic [3:0] TRACE_LAST_IDX = 4'hF;
	localparam logic [3:0] TRACE_FIRST_IDX = 4'h0;
	localparam logic [1:0] LOCK_MSG_COUNT = 2'h3;
	localparam logic [1:0] UNLOCK_MSG_COUNT = 2'h3;
	localparam int ALIGN_BIT = 7;

	// memory pages inside a 256-byte group (upper nibble of the offset)
	localparam logic [3:0] ACC_TRACE_PAGE = 4'h4;
	localparam logic [3:0] EXP_TRACE_PAGE = 4'h5;

	// ------------------------------------------------------------------
	// tandem multiframe layout (frame index counted from 0)
	// ------------------------------------------------------------------
	localparam logic [6:0] MF_LAST_FRAME = 7'h4B;
	localparam logic [6:0] FAS_LAST_FRAME = 7'h07;
	localparam logic [6:0] TRACE_FIRST_FRAME = 7'h08;
	localparam logic [6:0] TRACE_LAST_FRAME = 7'h47;
	localparam logic [6:0] RDI_FRAME = 7'h48;
	localparam logic [6:0] ODI_FRAME = 7'h49;
	localparam logic [15:0] FAS_PATTERN = 16'hFFFE;
	localparam logic [1:0] TRACE_BYTE_END = 2'h3;

	// ------------------------------------------------------------------
	// persistence and alignment counts
	// ------------------------------------------------------------------
	localparam logic [2:0] PERSIST_COUNT = 3'h5;
	localparam logic [2:0] LOM_SET_COUNT = 3'h4;
	localparam logic [2:0] LOM_CLR_COUNT = 3'h3;
	localparam logic [5:0] UNEQ_PATTERN = 6'h00;
	localparam int CNT_W = 8;

	// ------------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [1:0] bip;
		logic fixed_one;
		logic ais;
		logic rei;
		logic oei;
		logic [1:0] mf;
	} ttm_tandem_byte_t;

	typedef struct packed {
		logic en;
		logic [7:0] addr;
		logic [7:0] data;
	} ttm_mem_wr_t;

endpackage

// >>> ttm_persist.sv
// module: five-in-a-row persistence filter for one alarm bit
`timescale 1ns/1ps
module ttm_persist
	import ttm_pkg::*;
#(
	parameter logic [2:0] COUNT = PERSIST_COUNT
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// sample stream
	input wire logic i_clear,
	input wire logic i_valid,
	input wire logic i_sample,
	// filtered state
	output logic o_state
);

	logic state_q;
	logic [2:0] run_q;
	logic differs;
	logic [2:0] run_inc;
	logic flip;

	assign differs = i_sample != state_q;
	assign run_inc = run_q + 3'h1;
	assign flip = differs && (run_inc == COUNT);

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			state_q <= 1'b0;
			run_q <= 3'h0;
		end else if (i_clear) begin
			state_q <= 1'b0;
			run_q <= 3'h0;
		end else if (i_valid) begin
			// one agreeing sample breaks the run
			state_q <= flip ? i_sample : state_q;
			run_q <= (differs && !flip) ? run_inc : 3'h0;
		end
	end

	assign o_state = state_q;

endmodule // ttm_persist

// >>> ttm_monitor.sv
// module: path trace lock engine and tandem overhead monitor (top)
//
// Function
// - lock when received trace equals accepted for three whole messages
// - lose lock after three messages each with a differing byte
// - once locked, compare accepted with expected trace; any difference flags
// - path mismatch stays set while locked; only lock loss or comparison off clears it
// - accepted trace written once; corrupting alignment byte forces restart
// - tandem runs only with tandem enable 1 and trace size 0
// - tandem byte: bip, fixed one, ais, rei, oei, multiframe bits
// - bip-2 errors counted per bit, or per block when selected
// - tandem ais declared and cleared after five agreeing frames
// - remote error counter counts bytes with bit 5 set
// - outgoing error counter counts bytes with bit 6 set
// - 76-frame multiframe: alignment, 16 trace bytes, rdi, odi, zeros
// - multiframe loss after four errored alignments, recover after three good
// - tandem trace uses same lock engine; mismatch clears on match
// - remote defect after five multiframes of frame 73 bit 8 agreeing
// - outgoing defect after five multiframes of frame 74 bit 7 agreeing
// - unequipped after five bytes XX000000, exit after five others
// - enabling comparison sets lock loss, clears mismatch, starts search
// - search for msb pattern one then fifteen zeros, capturing bytes as it goes
// - accepted trace at offsets 40-4F, expected trace at 50-5F
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// trace lock engine
// ----------------------------------------------------------------------
module ttm_trace_lock
	import ttm_pkg::*;
#(
	parameter bit STICKY_MISMATCH = 1'b1
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// control and byte stream
	input wire logic i_enable,
	input wire logic i_byte_valid,
	input wire logic [7:0] i_byte,
	// software memory access
	input wire ttm_mem_wr_t i_mem_wr,
	input wire logic [7:0] i_rd_addr,
	// status
	output logic o_loss_of_lock,
	output logic o_mismatch,
	output logic [7:0] o_rd_data
);

	typedef enum logic [1:0] {ST_OFF, ST_SEARCH, ST_CHECK, ST_LOCKED}
		ttm_lock_state_t;

	ttm_lock_state_t state_q, state_d;
	logic [3:0] idx_q, idx_d;
	logic [1:0] run_q, run_d;
	logic msg_diff_q, msg_diff_d;
	logic exp_diff_q, exp_diff_d;
	logic lol_q, lol_d;
	logic mis_q, mis_d;
	logic [7:0] rd_q;
	logic [7:0] accepted_trace [TRACE_LEN];
	logic [7:0] expected_trace [TRACE_LEN];

	logic byte_msb;
	logic at_end;
	logic byte_diff;
	logic msg_bad;
	logic exp_bad;
	logic sw_acc_wr;
	logic sw_exp_wr;
	logic acc_corrupt;
	logic cap_wr;
	logic [3:0] cap_addr;
	logic [3:0] rd_idx;

	// ------------------------------------------------------------------
	// decode
	// ------------------------------------------------------------------
	assign byte_msb = i_byte[ALIGN_BIT];
	assign at_end = idx_q == TRACE_LAST_IDX;
	assign byte_diff = i_byte != accepted_trace[idx_q];
	assign msg_bad = msg_diff_q || byte_diff;
	assign exp_bad = exp_diff_q ||
		(accepted_trace[idx_q] != expected_trace[idx_q]);
	assign sw_acc_wr = i_mem_wr.en &&
		(i_mem_wr.addr[7:4] == ACC_TRACE_PAGE);
	assign sw_exp_wr = i_mem_wr.en &&
		(i_mem_wr.addr[7:4] == EXP_TRACE_PAGE);
	// only a write that breaks the msb pattern disturbs the engine
	assign acc_corrupt = sw_acc_wr &&
		((i_mem_wr.addr[3:0] == TRACE_FIRST_IDX) ?
		!i_mem_wr.data[ALIGN_BIT] : i_mem_wr.data[ALIGN_BIT]);
	// capture runs only while hunting; a set msb restarts at byte 0
	assign cap_wr = i_enable && (state_q == ST_SEARCH) && i_byte_valid &&
		(byte_msb || (idx_q != TRACE_FIRST_IDX));
	assign cap_addr = byte_msb ? TRACE_FIRST_IDX : idx_q;
	assign rd_idx = i_rd_addr[3:0];

	// ------------------------------------------------------------------
	// trace memories
	// ------------------------------------------------------------------
	// software write wins over capture in the same cycle
	always_ff @(posedge i_clk) begin
		if (sw_acc_wr) begin
			accepted_trace[i_mem_wr.addr[3:0]] <= i_mem_wr.data;
		end else if (cap_wr) begin
			accepted_trace[cap_addr] <= i_byte;
		end
		if (sw_exp_wr) begin
			expected_trace[i_mem_wr.addr[3:0]] <= i_mem_wr.data;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			rd_q <= 8'h00;
		end else if (i_rd_addr[7:4] == ACC_TRACE_PAGE) begin
			rd_q <= accepted_trace[rd_idx];
		end else if (i_rd_addr[7:4] == EXP_TRACE_PAGE) begin
			rd_q <= expected_trace[rd_idx];
		end else begin
			rd_q <= 8'h00;
		end
	end

	// ------------------------------------------------------------------
	// lock state machine
	// ------------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		idx_d = idx_q;
		run_d = run_q;
		msg_diff_d = msg_diff_q;
		exp_diff_d = exp_diff_q;
		lol_d = lol_q;
		mis_d = mis_q;
		if (!i_enable) begin
			// alarms are meaningless with comparison off
			state_d = ST_OFF;
			idx_d = 4'h0;
			run_d = 2'h0;
			lol_d = 1'b0;
			mis_d = 1'b0;
		end else if (state_q == ST_OFF || acc_corrupt) begin
			state_d = ST_SEARCH;
			idx_d = 4'h0;
			run_d = 2'h0;
			lol_d = 1'b1;
			mis_d = 1'b0;
		end else if (i_byte_valid) begin
			unique case (state_q)
				ST_OFF: begin
					state_d = ST_SEARCH;
				end
				ST_SEARCH: begin
					if (byte_msb) begin
						idx_d = 4'h1;
					end else if (idx_q != TRACE_FIRST_IDX) begin
						idx_d = idx_q + 4'h1;
						if (at_end) begin
							state_d = ST_CHECK;
							run_d = 2'h0;
						end
					end
				end
				ST_CHECK: begin
					idx_d = idx_q + 4'h1;
					if (byte_diff) begin
						// any slip before lock sends us hunting again
						state_d = ST_SEARCH;
						idx_d = 4'h0;
					end else if (at_end) begin
						if (run_q == LOCK_MSG_COUNT - 2'h1) begin
							state_d = ST_LOCKED;
							lol_d = 1'b0;
							run_d = 2'h0;
							msg_diff_d = 1'b0;
							exp_diff_d = 1'b0;
						end else begin
							run_d = run_q + 2'h1;
						end
					end
				end
				ST_LOCKED: begin
					idx_d = idx_q + 4'h1;
					msg_diff_d = msg_bad;
					exp_diff_d = exp_bad;
					if (at_end) begin
						msg_diff_d = 1'b0;
						exp_diff_d = 1'b0;
						if (exp_bad) begin
							mis_d = 1'b1;
						end else if (!STICKY_MISMATCH) begin
							mis_d = 1'b0;
						end
						// with STICKY_MISMATCH only unlock or disable clears
						if (!msg_bad) begin
							run_d = 2'h0;
						end else if (run_q == UNLOCK_MSG_COUNT - 2'h1) begin
							state_d = ST_SEARCH;
							idx_d = 4'h0;
							run_d = 2'h0;
							lol_d = 1'b1;
							mis_d = 1'b0;
						end else begin
							run_d = run_q + 2'h1;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			state_q <= ST_OFF;
			idx_q <= 4'h0;
			run_q <= 2'h0;
			msg_diff_q <= 1'b0;
			exp_diff_q <= 1'b0;
			lol_q <= 1'b0;
			mis_q <= 1'b0;
		end else begin
			state_q <= state_d;
			idx_q <= idx_d;
			run_q <= run_d;
			msg_diff_q <= msg_diff_d;
			exp_diff_q <= exp_diff_d;
			lol_q <= lol_d;
			mis_q <= mis_d;
		end
	end

	assign o_loss_of_lock = lol_q;
	assign o_mismatch = mis_q;
	assign o_rd_data = rd_q;

endmodule // ttm_trace_lock

// ----------------------------------------------------------------------
// top: path trace and tandem connection monitor
// ----------------------------------------------------------------------
module ttm_monitor
	import ttm_pkg::*;
(
	// clock and reset
	input wire logic I_CLOCK,
	input wire logic I_RST,
	// path trace byte stream
	input wire logic I_TRACE_VALID,
	input wire logic [7:0] I_TRACE_BYTE,
	// tandem byte stream, one per frame
	input wire logic I_TANDEM_VALID,
	input wire ttm_tandem_byte_t I_TANDEM_BYTE,
	input wire logic [1:0] I_TANDEM_BIP2,
	// control
	input wire logic I_TRACE_COMPARE_ENABLE,
	input wire logic I_TRACE_SIZE_SELECT,
	input wire logic I_TANDEM_ENABLE,
	input wire logic I_BLOCK_COUNT,
	input wire logic I_COUNTER_CLEAR,
	// software memory access
	input wire ttm_mem_wr_t I_TRACE_MEM_WR,
	input wire logic [7:0] I_TRACE_RD_ADDR,
	input wire ttm_mem_wr_t I_TANDEM_MEM_WR,
	input wire logic [7:0] I_TANDEM_RD_ADDR,
	// path trace status
	output logic O_TRACE_LOSS_OF_LOCK,
	output logic O_TRACE_MISMATCH,
	output logic [7:0] O_TRACE_RD_DATA,
	// tandem status
	output logic O_TANDEM_AIS,
	output logic O_TANDEM_MULTIFRAME_LOSS,
	output logic O_TANDEM_LOCK_LOSS,
	output logic O_TANDEM_TRACE_MISMATCH,
	output logic O_TANDEM_REMOTE_DEFECT,
	output logic O_TANDEM_OUTGOING_DEFECT,
	output logic O_TANDEM_UNEQUIPPED,
	output logic [7:0] O_TANDEM_RD_DATA,
	// tandem counters
	output logic [CNT_W-1:0] O_BIP2_ERROR_COUNT,
	output logic [CNT_W-1:0] O_REMOTE_ERROR_COUNT,
	output logic [CNT_W-1:0] O_OUTGOING_ERROR_COUNT
);

	// counters stick at all-ones rather than wrap
	function automatic logic [CNT_W-1:0] cnt_next(
		input logic [CNT_W-1:0] cur,
		input logic [1:0] inc
	);
		logic [CNT_W:0] sum;
		sum = {1'b0, cur} + {{(CNT_W-1){1'b0}}, inc};
		cnt_next = sum[CNT_W] ? {CNT_W{1'b1}} : sum[CNT_W-1:0];
	endfunction

	logic trace_on;
	logic tc_active;
	logic tc_vld;
	logic [1:0] bip_err;
	logic [1:0] bip_inc;
	logic [1:0] rei_inc;
	logic [1:0] oei_inc;
	logic [CNT_W-1:0] bip_cnt_q;
	logic [CNT_W-1:0] rei_cnt_q;
	logic [CNT_W-1:0] oei_cnt_q;
	logic [CNT_W-1:0] bip_base;
	logic [CNT_W-1:0] rei_base;
	logic [CNT_W-1:0] oei_base;
	logic [6:0] mf_idx_q;
	logic [15:0] fas_sh_q;
	logic [15:0] fas_sh_d;
	logic fas_hit;
	logic at_fas;
	logic lom_q;
	logic [2:0] lom_bad_q;
	logic [2:0] lom_good_q;
	logic [5:0] tb_sh_q;
	logic in_trace;
	logic tc_trace_vld;
	logic [7:0] tc_trace_byte;
	logic [3:0] flt_valid;
	logic [3:0] flt_sample;
	logic [3:0] flt_state;

	// ------------------------------------------------------------------
	// path trace
	// ------------------------------------------------------------------
	assign trace_on = I_TRACE_COMPARE_ENABLE && !I_TRACE_SIZE_SELECT;

	ttm_trace_lock #(
		.STICKY_MISMATCH(1'b1)
	) u_path_lock (
		.i_clk(I_CLOCK),
		.i_rst(I_RST),
		.i_enable(trace_on),
		.i_byte_valid(I_TRACE_VALID),
		.i_byte(I_TRACE_BYTE),
		.i_mem_wr(I_TRACE_MEM_WR),
		.i_rd_addr(I_TRACE_RD_ADDR),
		.o_loss_of_lock(O_TRACE_LOSS_OF_LOCK),
		.o_mismatch(O_TRACE_MISMATCH),
		.o_rd_data(O_TRACE_RD_DATA)
	);

	// ------------------------------------------------------------------
	// tandem byte decode and counters
	// ------------------------------------------------------------------
	assign tc_active = I_TANDEM_ENABLE && !I_TRACE_SIZE_SELECT;
	assign tc_vld = I_TANDEM_VALID && tc_active;
	assign bip_err = I_TANDEM_BYTE.bip ^ I_TANDEM_BIP2;
	assign bip_inc = !tc_vld ? 2'h0 :
		I_BLOCK_COUNT ? {1'b0, |bip_err} :
		({1'b0, bip_err[1]} + {1'b0, bip_err[0]});
	assign rei_inc = {1'b0, tc_vld && I_TANDEM_BYTE.rei};
	assign oei_inc = {1'b0, tc_vld && I_TANDEM_BYTE.oei};
	// a clear in the same cycle as an error keeps that error
	assign bip_base = I_COUNTER_CLEAR ? {CNT_W{1'b0}} : bip_cnt_q;
	assign rei_base = I_COUNTER_CLEAR ? {CNT_W{1'b0}} : rei_cnt_q;
	assign oei_base = I_COUNTER_CLEAR ? {CNT_W{1'b0}} : oei_cnt_q;

	always_ff @(posedge I_CLOCK or posedge I_RST) begin
		if (I_RST) begin
			bip_cnt_q <= {CNT_W{1'b0}};
			rei_cnt_q <= {CNT_W{1'b0}};
			oei_cnt_q <= {CNT_W{1'b0}};
		end else begin
			bip_cnt_q <= cnt_next(bip_base, bip_inc);
			rei_cnt_q <= cnt_next(rei_base, rei_inc);
			oei_cnt_q <= cnt_next(oei_base, oei_inc);
		end
	end

	// ------------------------------------------------------------------
	// multiframe alignment
	// ------------------------------------------------------------------
	assign fas_sh_d = {fas_sh_q[13:0], I_TANDEM_BYTE.mf};
	assign fas_hit = fas_sh_d == FAS_PATTERN;
	assign at_fas = mf_idx_q == FAS_LAST_FRAME;

	// while lost, any position of the pattern realigns the frame count
	always_ff @(posedge I_CLOCK or posedge I_RST) begin
		if (I_RST) begin
			mf_idx_q <= 7'h00;
			fas_sh_q <= 16'h0000;
			lom_q <= 1'b1;
			lom_bad_q <= 3'h0;
			lom_good_q <= 3'h0;
		end else if (!tc_active) begin
			mf_idx_q <= 7'h00;
			fas_sh_q <= 16'h0000;
			lom_q <= 1'b1;
			lom_bad_q <= 3'h0;
			lom_good_q <= 3'h0;
		end else if (tc_vld) begin
			fas_sh_q <= fas_sh_d;
			if (lom_q && fas_hit) begin
				mf_idx_q <= TRACE_FIRST_FRAME;
			end else if (mf_idx_q == MF_LAST_FRAME) begin
				mf_idx_q <= 7'h00;
			end else begin
				mf_idx_q <= mf_idx_q + 7'h01;
			end
			if (lom_q) begin
				if (fas_hit) begin
					lom_good_q <= lom_good_q + 3'h1;
					if (lom_good_q + 3'h1 == LOM_CLR_COUNT) begin
						lom_q <= 1'b0;
						lom_bad_q <= 3'h0;
					end
				end else if (at_fas) begin
					lom_good_q <= 3'h0;
				end
			end else if (at_fas) begin
				if (fas_hit) begin
					lom_bad_q <= 3'h0;
				end else begin
					lom_bad_q <= lom_bad_q + 3'h1;
					if (lom_bad_q + 3'h1 == LOM_SET_COUNT) begin
						lom_q <= 1'b1;
						lom_good_q <= 3'h0;
					end
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// tandem trace assembly (two bits per frame, four frames per byte)
	// ------------------------------------------------------------------
	assign in_trace = (mf_idx_q >= TRACE_FIRST_FRAME) &&
		(mf_idx_q <= TRACE_LAST_FRAME);
	assign tc_trace_byte = {tb_sh_q, I_TANDEM_BYTE.mf};
	assign tc_trace_vld = tc_vld && !lom_q && in_trace &&
		(mf_idx_q[1:0] == TRACE_BYTE_END);

	always_ff @(posedge I_CLOCK or posedge I_RST) begin
		if (I_RST) begin
			tb_sh_q <= 6'h00;
		end else if (tc_vld) begin
			tb_sh_q <= {tb_sh_q[3:0], I_TANDEM_BYTE.mf};
		end
	end

	ttm_trace_lock #(
		.STICKY_MISMATCH(1'b0)
	) u_tandem_lock (
		.i_clk(I_CLOCK),
		.i_rst(I_RST),
		.i_enable(tc_active),
		.i_byte_valid(tc_trace_vld),
		.i_byte(tc_trace_byte),
		.i_mem_wr(I_TANDEM_MEM_WR),
		.i_rd_addr(I_TANDEM_RD_ADDR),
		.o_loss_of_lock(O_TANDEM_LOCK_LOSS),
		.o_mismatch(O_TANDEM_TRACE_MISMATCH),
		.o_rd_data(O_TANDEM_RD_DATA)
	);

	// ------------------------------------------------------------------
	// persistence filters: ais, unequipped, remote and outgoing defect
	// ------------------------------------------------------------------
	assign flt_valid[0] = tc_vld;
	assign flt_sample[0] = I_TANDEM_BYTE.ais;
	assign flt_valid[1] = tc_vld;
	assign flt_sample[1] = I_TANDEM_BYTE[5:0] == UNEQ_PATTERN;
	assign flt_valid[2] = tc_vld && !lom_q && (mf_idx_q == RDI_FRAME);
	assign flt_sample[2] = I_TANDEM_BYTE.mf[0];
	assign flt_valid[3] = tc_vld && !lom_q && (mf_idx_q == ODI_FRAME);
	assign flt_sample[3] = I_TANDEM_BYTE.mf[1];

	for (genvar g = 0; g < 4; g++) begin : g_flt
		ttm_persist #(
			.COUNT(PERSIST_COUNT)
		) u_flt (
			.i_clk(I_CLOCK),
			.i_rst(I_RST),
			.i_clear(!tc_active),
			.i_valid(flt_valid[g]),
			.i_sample(flt_sample[g]),
			.o_state(flt_state[g])
		);
	end

	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------
	assign O_TANDEM_AIS = flt_state[0];
	assign O_TANDEM_UNEQUIPPED = flt_state[1];
	assign O_TANDEM_REMOTE_DEFECT = flt_state[2];
	assign O_TANDEM_OUTGOING_DEFECT = flt_state[3];
	assign O_TANDEM_MULTIFRAME_LOSS = lom_q;
	assign O_BIP2_ERROR_COUNT = bip_cnt_q;
	assign O_REMOTE_ERROR_COUNT = rei_cnt_q;
	assign O_OUTGOING_ERROR_COUNT = oei_cnt_q;

endmodule // ttm_monitor

// >>> ttm_monitor_checker.sv
// checker: port-level properties of the trace and tandem monitor
`timescale 1ns/1ps
module ttm_monitor_checker
	import ttm_pkg::*;
(
	// clock and reset
	input wire logic I_CLOCK,
	input wire logic I_RST,
	// watched inputs
	input wire logic I_TANDEM_VALID,
	input wire ttm_tandem_byte_t I_TANDEM_BYTE,
	input wire logic [1:0] I_TANDEM_BIP2,
	input wire logic I_TRACE_COMPARE_ENABLE,
	input wire logic I_TRACE_SIZE_SELECT,
	input wire logic I_TANDEM_ENABLE,
	input wire logic I_BLOCK_COUNT,
	input wire logic I_COUNTER_CLEAR,
	// watched outputs
	input wire logic O_TRACE_LOSS_OF_LOCK,
	input wire logic O_TRACE_MISMATCH,
	input wire logic O_TANDEM_AIS,
	input wire logic O_TANDEM_MULTIFRAME_LOSS,
	input wire logic O_TANDEM_REMOTE_DEFECT,
	input wire logic [CNT_W-1:0] O_BIP2_ERROR_COUNT,
	input wire logic [CNT_W-1:0] O_REMOTE_ERROR_COUNT,
	input wire logic [CNT_W-1:0] O_OUTGOING_ERROR_COUNT
);
	default clocking @(posedge I_CLOCK); endclocking
	default disable iff (I_RST);
	// ----
	// helper: run length of ais samples
	// ----
	wire logic on = I_TANDEM_ENABLE && !I_TRACE_SIZE_SELECT;
	wire logic take = I_TANDEM_VALID && on && !I_COUNTER_CLEAR;
	logic [2:0] ais_run_q;
	always_ff @(posedge I_CLOCK or posedge I_RST) begin
		if (I_RST)
			ais_run_q <= 3'h0;
		else if (!on || (I_TANDEM_VALID && !I_TANDEM_BYTE.ais))
			ais_run_q <= 3'h0;
		else if (I_TANDEM_VALID && ais_run_q != 3'h7)
			ais_run_q <= ais_run_q + 3'h1;
	end
	// ----
	// properties
	// ----
	a_lol_on_enable: assert property (
		$rose(I_TRACE_COMPARE_ENABLE) && !I_TRACE_SIZE_SELECT
		|=> O_TRACE_LOSS_OF_LOCK && !O_TRACE_MISMATCH)
		else $error("lock loss not forced on enable");
	a_mis_when_locked: assert property (
		O_TRACE_MISMATCH |-> !O_TRACE_LOSS_OF_LOCK)
		else $error("mismatch while unlocked");
	a_mis_sticky: assert property (
		$fell(O_TRACE_MISMATCH) |-> O_TRACE_LOSS_OF_LOCK
		|| !$past(I_TRACE_COMPARE_ENABLE) || $past(I_TRACE_SIZE_SELECT))
		else $error("mismatch cleared while locked");
	a_off_clears_tandem: assert property (
		!on |=> O_TANDEM_MULTIFRAME_LOSS && !O_TANDEM_AIS
		&& !O_TANDEM_REMOTE_DEFECT)
		else $error("tandem state kept while inactive");
	a_ais_five_ones: assert property (
		$rose(O_TANDEM_AIS) |-> ais_run_q >= 3'h5)
		else $error("ais raised too early");
	a_rei_counts: assert property (
		take && I_TANDEM_BYTE.rei && O_REMOTE_ERROR_COUNT != 8'hFF
		|=> O_REMOTE_ERROR_COUNT == $past(O_REMOTE_ERROR_COUNT) + 8'h01)
		else $error("remote error count missed");
	a_oei_counts: assert property (
		take && I_TANDEM_BYTE.oei && O_OUTGOING_ERROR_COUNT != 8'hFF
		|=> O_OUTGOING_ERROR_COUNT == $past(O_OUTGOING_ERROR_COUNT) + 8'h01)
		else $error("outgoing error count missed");
	a_bip_block: assert property (
		take && I_BLOCK_COUNT && I_TANDEM_BYTE.bip != I_TANDEM_BIP2
		&& O_BIP2_ERROR_COUNT != 8'hFF
		|=> O_BIP2_ERROR_COUNT == $past(O_BIP2_ERROR_COUNT) + 8'h01)
		else $error("block bip count wrong");
	c_lock: cover property ($fell(O_TRACE_LOSS_OF_LOCK));
	c_mismatch: cover property ($rose(O_TRACE_MISMATCH));
	c_rdi: cover property ($rose(O_TANDEM_REMOTE_DEFECT));
endmodule // ttm_monitor_checker

bind ttm_monitor ttm_monitor_checker ttm_monitor_checker_i (
	.I_CLOCK(I_CLOCK), .I_RST(I_RST), .I_TANDEM_VALID(I_TANDEM_VALID),
	.I_TANDEM_BYTE(I_TANDEM_BYTE), .I_TANDEM_BIP2(I_TANDEM_BIP2),
	.I_TRACE_COMPARE_ENABLE(I_TRACE_COMPARE_ENABLE),
	.I_TRACE_SIZE_SELECT(I_TRACE_SIZE_SELECT),
	.I_TANDEM_ENABLE(I_TANDEM_ENABLE), .I_BLOCK_COUNT(I_BLOCK_COUNT),
	.I_COUNTER_CLEAR(I_COUNTER_CLEAR),
	.O_TRACE_LOSS_OF_LOCK(O_TRACE_LOSS_OF_LOCK),
	.O_TRACE_MISMATCH(O_TRACE_MISMATCH), .O_TANDEM_AIS(O_TANDEM_AIS),
	.O_TANDEM_MULTIFRAME_LOSS(O_TANDEM_MULTIFRAME_LOSS),
	.O_TANDEM_REMOTE_DEFECT(O_TANDEM_REMOTE_DEFECT),
	.O_BIP2_ERROR_COUNT(O_BIP2_ERROR_COUNT),
	.O_REMOTE_ERROR_COUNT(O_REMOTE_ERROR_COUNT),
	.O_OUTGOING_ERROR_COUNT(O_OUTGOING_ERROR_COUNT));

// >>> ttm_far_end.sv
// partner: far-end source of path trace and tandem overhead bytes
`timescale 1ns/1ps
module ttm_far_end
	import ttm_pkg::*;
(
	// clock
	input wire logic i_clk,
	// byte streams
	output logic o_trace_valid = 1'b0,
	output logic [7:0] o_trace_byte = 8'h00,
	output logic o_tandem_valid = 1'b0,
	output ttm_tandem_byte_t o_tandem_byte = '0
);
	task automatic trace_msg(input logic [127:0] m);
		for (int i = 15; i >= 0; i--) begin
			@(posedge i_clk);
			o_trace_valid <= 1'b1;
			o_trace_byte <= m[i*8 +: 8];
		end
		@(posedge i_clk);
		o_trace_valid <= 1'b0;
		// released: no stale byte for the sampler to reuse
		o_trace_byte <= ~o_trace_byte;
	endtask
	task automatic frame(input ttm_tandem_byte_t b);
		@(posedge i_clk);
		o_tandem_valid <= 1'b1;
		o_tandem_byte <= b;
	endtask
	task automatic idle;
		@(posedge i_clk);
		o_tandem_valid <= 1'b0;
		o_tandem_byte <= ~o_tandem_byte;
	endtask
	// one 76-frame multiframe; a bad alignment word flips one bit per frame
	task automatic multiframe(input logic [127:0] m, input bit ok, rd, od);
		ttm_tandem_byte_t b;
		for (int k = 0; k < 76; k++) begin
			b = 8'h20;
			if (k < 8)
				b.mf = FAS_PATTERN[15-2*k -: 2] ^ {1'b0, !ok};
			else if (k < 72)
				b.mf = m[127-8*((k-8)/4)-2*((k-8)%4) -: 2];
			else if (k == 72)
				b.mf = {1'b0, rd};
			else if (k == 73)
				b.mf = {od, 1'b0};
			else
				b.mf = 2'h0;
			frame(b);
		end
	endtask
endmodule // ttm_far_end

// >>> test_ttm_monitor.sv
// testbench: scenario sequence for the trace and tandem monitor
`timescale 1ns/1ps
module test_ttm_monitor;
	import ttm_pkg::*;
	// alignment byte first, then fifteen bytes with msb clear
	localparam logic [127:0] A = 128'hC1414243444546474849_4A4B4C4D4E4F;
	localparam logic [127:0] B = A ^ 128'h1;
	logic clk = 1'b0, rst = 1'b1, tv, kv;
	logic cmp = 1'b0, sz = 1'b0, ten = 1'b0, blk = 1'b0, clr = 1'b0;
	logic [1:0] bip2 = 2'h0;
	logic [7:0] tby, pra = 8'h00, kra = 8'h00, prd, krd, bc, rc, oc;
	ttm_tandem_byte_t kb;
	ttm_mem_wr_t pw = '0, kw = '0;
	logic lol, mis, ais, lom, kll, ktm, rdi, odi, uq;
	int n_mismatch = 0, check_count = 0;
	ttm_far_end far (.i_clk(clk), .o_trace_valid(tv),
		.o_trace_byte(tby), .o_tandem_valid(kv), .o_tandem_byte(kb));
	ttm_monitor ttm_monitor_i (.I_CLOCK(clk), .I_RST(rst),
		.I_TRACE_VALID(tv), .I_TRACE_BYTE(tby), .I_TANDEM_VALID(kv),
		.I_TANDEM_BYTE(kb), .I_TANDEM_BIP2(bip2),
		.I_TRACE_COMPARE_ENABLE(cmp), .I_TRACE_SIZE_SELECT(sz),
		.I_TANDEM_ENABLE(ten), .I_BLOCK_COUNT(blk), .I_COUNTER_CLEAR(clr),
		.I_TRACE_MEM_WR(pw), .I_TRACE_RD_ADDR(pra), .I_TANDEM_MEM_WR(kw),
		.I_TANDEM_RD_ADDR(kra), .O_TRACE_LOSS_OF_LOCK(lol),
		.O_TRACE_MISMATCH(mis), .O_TRACE_RD_DATA(prd), .O_TANDEM_AIS(ais),
		.O_TANDEM_MULTIFRAME_LOSS(lom), .O_TANDEM_LOCK_LOSS(kll),
		.O_TANDEM_TRACE_MISMATCH(ktm), .O_TANDEM_REMOTE_DEFECT(rdi),
		.O_TANDEM_OUTGOING_DEFECT(odi), .O_TANDEM_UNEQUIPPED(uq),
		.O_TANDEM_RD_DATA(krd), .O_BIP2_ERROR_COUNT(bc),
		.O_REMOTE_ERROR_COUNT(rc), .O_OUTGOING_ERROR_COUNT(oc));
	// ----
	// tasks
	// ----
	task automatic chk(input logic [7:0] s, e);
		check_count++;
		if (s !== e) begin
			n_mismatch++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic tk(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wr(input bit t, input logic [7:0] a, d);
		@(posedge clk);
		if (t) kw <= {1'b1, a, d};
		else pw <= {1'b1, a, d};
		@(posedge clk);
		kw.en <= 1'b0;
		pw.en <= 1'b0;
	endtask
	task automatic fr(input ttm_tandem_byte_t b, input int n);
		repeat (n) far.frame(b);
		far.idle;
		tk(1);
	endtask
	task automatic tally_and_finish;
		$display("checks=%0d mismatches=%0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	initial forever #2 clk = ~clk;
	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		tally_and_finish;
	end
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		tk(1);
		chk(8'({lol, mis, lom}), 8'h01);
		// expected message loaded before the far end sends it
		for (int i = 0; i < 16; i++)
			wr(0, 8'h50 + 8'(i), A[127-8*i -: 8]);
		@(posedge clk) cmp <= 1'b1;
		tk(2);
		chk(8'({lol, mis}), 8'h02);
		repeat (4) far.trace_msg(A);
		tk(1);
		chk(8'({lol, mis}), 8'h00);
		@(posedge clk) pra <= 8'h40;
		kra <= 8'h4F;
		tk(2);
		chk(prd, A[127:120]);
		wr(0, 8'h5F, 8'h00);
		far.trace_msg(A);
		tk(1);
		chk(8'(mis), 8'h01);
		wr(0, 8'h5F, A[7:0]);
		far.trace_msg(A);
		tk(1);
		chk(8'(mis), 8'h01);
		wr(0, 8'h40, 8'h00);
		tk(1);
		chk(8'({lol, mis}), 8'h02);
		repeat (4) far.trace_msg(A);
		repeat (2) far.trace_msg(B);
		tk(1);
		chk(8'(lol), 8'h00);
		far.trace_msg(B);
		tk(1);
		chk(8'(lol), 8'h01);
		$display("path trace test done");
		@(posedge clk) ten <= 1'b1;
		fr(8'hFC, 5);
		chk(8'(ais), 8'h01);
		chk(bc, 8'h0A);
		@(posedge clk) blk <= 1'b1;
		fr(8'h60, 5);
		chk(8'(ais), 8'h00);
		fr(8'hC0, 4);
		chk(8'(uq), 8'h00);
		fr(8'hC0, 1);
		chk(8'({kll, uq}), 8'h03);
		chk(bc, 8'h14);
		chk(rc, 8'h05);
		chk(oc, 8'h05);
		@(posedge clk) clr <= 1'b1;
		@(posedge clk) clr <= 1'b0;
		tk(1);
		chk(8'({bc, rc, oc} == 24'h0), 8'h01);
		for (int i = 0; i < 16; i++)
			wr(1, 8'h50 + 8'(i), A[127-8*i -: 8]);
		repeat (8) far.multiframe(A, 1, 1, 1);
		far.idle;
		tk(1);
		chk(8'({lom, kll, ktm}), 8'h00);
		chk(8'({rdi, odi, uq}), 8'h06);
		chk(krd, A[7:0]);
		wr(1, 8'h5F, 8'h00);
		far.multiframe(A, 1, 1, 1);
		far.idle;
		tk(1);
		chk(8'({kll, ktm}), 8'h01);
		wr(1, 8'h5F, A[7:0]);
		repeat (3) far.multiframe(A, 0, 0, 0);
		#1;
		chk(8'({lom, ktm}), 8'h00);
		far.multiframe(A, 0, 0, 0);
		far.idle;
		tk(1);
		chk(8'(lom), 8'h01);
		@(posedge clk) ten <= 1'b0;
		tk(2);
		chk(8'({lom, rdi, odi}), 8'h04);
		fr(8'hFC, 1);
		chk(rc, 8'h00);
		@(posedge clk) ten <= 1'b1;
		sz <= 1'b1;
		fr(8'hFC, 1);
		chk(rc, 8'h00);
		chk(8'({lol, lom}), 8'h01);
		$display("tandem test done");
		tally_and_finish;
	end
endmodule // test_ttm_monitor
